// ==== src/ccf_pkg.sv ====
// Purpose: shared types and constants of the core datapath and flag register
// Assumes: one core clock, byte-wide data space with 16-bit addresses
// Notes: instruction encoding is local to this core
package ccf_pkg;
  // ==========================================================
  // operation codes
  typedef enum logic [4:0] {
    nop_op, add_op, adc_op, sub_op, and_op, or_op, xor_op, move_op,
    imm_load_op, reg_bit_to_flag_op, flag_to_reg_bit_op, irq_gate_set_op,
    irq_gate_clear_op, io_read_op, io_write_op, direct_read_op,
    direct_write_op, data_fetch_op, data_write_op, table_read_op, call_op,
    irq_return_op, flash_self_write_op
  } ccf_op_t;

  // ==========================================================
  // carriers
  // fld: io address, or [4:0] source register, or [2:0] bit, or [1:0] pointer
  typedef struct packed {
    ccf_op_t op;
    logic [4:0] rd;
    logic [5:0] fld;
  } ccf_insn_t;

  typedef struct packed {
    logic gate;
    logic tcopy;
    logic half;
    logic sign;
    logic ovf;
    logic neg;
    logic zero;
    logic carry;
  } ccf_cpu_flag_register_t;

  typedef struct packed {
    logic [7:0] res;
    ccf_cpu_flag_register_t f;
  } ccf_alu_t;

  // ==========================================================
  // address map
  localparam logic [15:0] REG_LAST = 16'h001F;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] IO_LAST = 16'h005F;
  localparam logic [15:0] EXT_LAST = 16'h00FF;
  localparam logic [15:0] FLAG_DATA_ADDR = 16'h005F;
  localparam logic [5:0] FLAG_IO_ADDR = 6'h3F;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [4:0] SPW_LO = 5'h00;
  localparam logic [4:0] SPW_HI = 5'h01;
  localparam logic [1:0] SEL_X = 2'h0;
  localparam logic [1:0] SEL_Y = 2'h1;
  localparam logic [15:0] STEP1 = 16'h0001;
  localparam logic [15:0] STEP2 = 16'h0002;
endpackage

// ==== src/ccf_core.sv ====
// Purpose: 8-bit core datapath with prefetch, register file and flag register
// Assumes: PM_DATA and DM_RDATA are valid in the cycle their address is shown
// Notes: loads, table reads, calls and returns take extra cycles
//
// Overview of operation
// - next instruction is fetched while the current one executes
// - thirty-two byte registers, each accessed in one cycle
// - two operands read, computed and written back in one cycle
// - three register pairs act as pointers; Z also addresses flash tables
// - arithmetic updates the flag register to describe its result
// - one 16-bit word per program address; instructions use one or two
// - flash self-write works only when executed from the boot section
// - interrupt entry and calls push the return address onto the stack
// - each source has a vector; lowest vector address is served first
// - 64 io locations, also seen at data addresses 0x20 to 0x5F
// - extended io 0x60 to 0xFF only by data load and store forms
// - flag register at data 0x5F, io 0x3F, resets to zero, all writable
// - io address equals data offset minus 0x20
// - flag register is never saved or restored by hardware
// - bit 7 clear blocks every interrupt
// - accepting an interrupt clears bit 7; interrupt return sets it
// - dedicated instructions set and clear bit 7
// - bit 6 stores a copied register bit and loads it back
// - bit 5 records low nibble carry
// - bit 4 is set to negative xor overflow by each alu op
// - bit 3 holds two's complement overflow
// - bit 2 negative, bit 1 zero, bit 0 carry
`timescale 1ns/10ps
module ccf_core #(
  parameter int N_IRQ = 8,
  parameter logic [15:0] SP_RESET = 16'h04FF,
  parameter logic [15:0] BOOT_START = 16'h7000,
  parameter logic [15:0] VEC_BASE = 16'h0000,
  parameter logic [15:0] VEC_STRIDE = 16'h0002
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // program memory
  output logic [15:0] PM_ADDR,
  input wire logic [15:0] PM_DATA,
  output logic PM_WE,
  output logic [15:0] PM_WADDR,
  output logic [15:0] PM_WDATA,
  // data memory and peripheral space
  output logic [15:0] DM_ADDR,
  output logic [7:0] DM_WDATA,
  output logic DM_WE,
  output logic DM_RE,
  input wire logic [7:0] DM_RDATA,
  // interrupts
  input wire logic [N_IRQ-1:0] IRQ_REQ,
  output logic [N_IRQ-1:0] IRQ_ACK,
  // flag register view
  output logic [7:0] FLAGS
);
  typedef enum logic [2:0] {
    st_exec, st_load, st_push, st_pop_hi, st_pop_lo, st_table
  } ccf_state_t;

  logic [7:0] rf [32];
  ccf_pkg::ccf_insn_t ir_reg;
  ccf_pkg::ccf_cpu_flag_register_t cpu_flag_register_reg, cpu_flag_register_next;
  ccf_pkg::ccf_alu_t alu;
  ccf_state_t state_reg;
  logic ir_valid_reg, dm_we_reg, dm_re_reg, pm_we_reg;
  logic [15:0] pc_reg, ir_pc_reg, sp_reg, dm_addr_reg, ret_pc_reg, ld_addr_reg;
  logic [15:0] pm_waddr_reg, pm_wdata_reg, mem_addr, ptr_val, z_val, vec, ret_addr;
  logic [7:0] dm_wdata_reg, ret_hi_reg, rd_val, rr_val, load_val, bit_mask;
  logic [4:0] ld_dst_reg, rf_wa;
  logic [7:0] rf_wd;
  logic [N_IRQ-1:0] irq_ack_reg, irq_pick;
  logic rf_we, exec, take_irq, two_word, fetch_en, is_load, is_store;

  // ==========================================================
  // helper functions
  function automatic logic is_ext(input logic [15:0] a);
    return (a > ccf_pkg::REG_LAST) && (a != ccf_pkg::FLAG_DATA_ADDR);
  endfunction

  function automatic logic [15:0] pair(input logic [4:0] lo);
    return {rf[lo + ccf_pkg::SPW_HI], rf[lo]};
  endfunction

  // lowest index wins, so the lowest vector address is served first
  function automatic logic [N_IRQ-1:0] lowest(input logic [N_IRQ-1:0] r);
    return r & (~r + {{(N_IRQ-1){1'b0}}, 1'b1});
  endfunction

  function automatic ccf_pkg::ccf_alu_t alu_f(input ccf_pkg::ccf_op_t op,
      input logic [7:0] a, input logic [7:0] b, input ccf_pkg::ccf_cpu_flag_register_t s);
    logic [8:0] sum;
    logic [4:0] hs;
    logic ci;
    ccf_pkg::ccf_alu_t r;
    r.f = s;
    ci = (op == ccf_pkg::adc_op) && s.carry;
    sum = '0;
    hs = '0;
    if (op == ccf_pkg::add_op || op == ccf_pkg::adc_op) begin
      sum = {1'b0, a} + {1'b0, b} + 9'(ci);
      hs = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
      r.res = sum[7:0];
      r.f.ovf = (a[7] == b[7]) && (r.res[7] != a[7]);
    end else if (op == ccf_pkg::sub_op) begin
      sum = {1'b0, a} - {1'b0, b};
      hs = {1'b0, a[3:0]} - {1'b0, b[3:0]};
      r.res = sum[7:0];
      r.f.ovf = (a[7] != b[7]) && (r.res[7] != a[7]);
    end else begin
      // logic ops leave carry and half carry untouched
      r.res = (op == ccf_pkg::and_op) ? (a & b) : (op == ccf_pkg::or_op) ? (a | b) : (a ^ b);
      r.f.ovf = 1'b0;
    end
    if (op == ccf_pkg::add_op || op == ccf_pkg::adc_op || op == ccf_pkg::sub_op) begin
      r.f.carry = sum[8];
      r.f.half = hs[4];
    end
    r.f.neg = r.res[7];
    r.f.zero = (r.res == 8'h00);
    r.f.sign = r.f.neg ^ r.f.ovf;
    return r;
  endfunction

  // ==========================================================
  // decode and operand selection
  assign exec = (state_reg == st_exec) && ir_valid_reg;
  assign take_irq = exec && cpu_flag_register_reg.gate && (|IRQ_REQ);
  assign irq_pick = lowest(IRQ_REQ);
  assign fetch_en = (state_reg == st_exec) || (state_reg == st_load) || (state_reg == st_push);
  assign two_word = ir_reg.op inside {ccf_pkg::imm_load_op, ccf_pkg::direct_read_op,
                                      ccf_pkg::direct_write_op, ccf_pkg::call_op};
  assign is_load = ir_reg.op inside {ccf_pkg::io_read_op, ccf_pkg::direct_read_op,
                                     ccf_pkg::data_fetch_op};
  assign is_store = ir_reg.op inside {ccf_pkg::io_write_op, ccf_pkg::direct_write_op,
                                      ccf_pkg::data_write_op};
  assign rd_val = rf[ir_reg.rd];
  assign rr_val = rf[ir_reg.fld[4:0]];
  assign alu = alu_f(ir_reg.op, rd_val, rr_val, cpu_flag_register_reg);
  assign bit_mask = 8'h01 << ir_reg.fld[2:0];
  assign z_val = pair(ccf_pkg::PTR_Z_LO);
  assign ptr_val = (ir_reg.fld[1:0] == ccf_pkg::SEL_X) ? pair(ccf_pkg::PTR_X_LO) :
                   (ir_reg.fld[1:0] == ccf_pkg::SEL_Y) ? pair(ccf_pkg::PTR_Y_LO) : z_val;
  assign ret_addr = pc_reg + ccf_pkg::STEP1;

  // io forms carry only six address bits, so they never reach the extended window
  always_comb begin
    unique case (ir_reg.op)
      ccf_pkg::io_read_op, ccf_pkg::io_write_op:
        mem_addr = {10'h000, ir_reg.fld} + ccf_pkg::IO_BASE;
      ccf_pkg::direct_read_op, ccf_pkg::direct_write_op: mem_addr = PM_DATA;
      default: mem_addr = ptr_val;
    endcase
  end

  // vector position of the chosen source
  always_comb begin
    vec = VEC_BASE;
    for (int i = 0; i < N_IRQ; i++) begin
      if (irq_pick[i]) begin
        vec = VEC_BASE + 16'(i) * VEC_STRIDE;
      end
    end
  end

  // returning data of a two-cycle load; registers and flags are internal
  assign load_val = (ld_addr_reg <= ccf_pkg::REG_LAST) ? rf[ld_addr_reg[4:0]] :
                    (ld_addr_reg == ccf_pkg::FLAG_DATA_ADDR) ? cpu_flag_register_reg : DM_RDATA;

  // ==========================================================
  // register file and flag next values
  always_comb begin
    rf_we = 1'b0;
    rf_wa = ir_reg.rd;
    rf_wd = alu.res;
    cpu_flag_register_next = cpu_flag_register_reg;
    if (state_reg == st_load) begin
      rf_we = 1'b1;
      rf_wa = ld_dst_reg;
      rf_wd = load_val;
    end else if (state_reg == st_table) begin
      rf_we = 1'b1;
      rf_wa = ld_dst_reg;
      rf_wd = ld_addr_reg[0] ? PM_DATA[15:8] : PM_DATA[7:0];
    end else if (state_reg == st_pop_lo) begin
      cpu_flag_register_next.gate = 1'b1;
    end else if (take_irq) begin
      cpu_flag_register_next.gate = 1'b0;
    end else if (exec) begin
      unique case (ir_reg.op)
        ccf_pkg::add_op, ccf_pkg::adc_op, ccf_pkg::sub_op, ccf_pkg::and_op,
        ccf_pkg::or_op, ccf_pkg::xor_op: begin
          rf_we = 1'b1;
          cpu_flag_register_next = alu.f;
        end
        ccf_pkg::move_op: begin
          rf_we = 1'b1;
          rf_wd = rr_val;
        end
        ccf_pkg::imm_load_op: begin
          rf_we = 1'b1;
          rf_wd = PM_DATA[7:0];
        end
        ccf_pkg::reg_bit_to_flag_op: cpu_flag_register_next.tcopy = |(rd_val & bit_mask);
        ccf_pkg::flag_to_reg_bit_op: begin
          rf_we = 1'b1;
          rf_wd = cpu_flag_register_reg.tcopy ? (rd_val | bit_mask) : (rd_val & ~bit_mask);
        end
        ccf_pkg::irq_gate_set_op: cpu_flag_register_next.gate = 1'b1;
        ccf_pkg::irq_gate_clear_op: cpu_flag_register_next.gate = 1'b0;
        ccf_pkg::io_write_op, ccf_pkg::direct_write_op, ccf_pkg::data_write_op: begin
          if (mem_addr == ccf_pkg::FLAG_DATA_ADDR) begin
            cpu_flag_register_next = rd_val;
          end
          rf_we = (mem_addr <= ccf_pkg::REG_LAST);
          rf_wa = mem_addr[4:0];
          rf_wd = rd_val;
        end
        default: ;
      endcase
    end
  end

  // register file: data only, no reset
  always_ff @(posedge CLK) begin
    if (rf_we) begin
      rf[rf_wa] <= rf_wd;
    end
  end

  // flag register; software must save it itself around handlers
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cpu_flag_register_reg <= ccf_pkg::FLAG_RESET;
    end else begin
      cpu_flag_register_reg <= cpu_flag_register_next;
    end
  end

  // ==========================================================
  // sequencer: fetch, memory traffic and stack
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= st_exec;
      pc_reg <= '0;
      ir_reg <= '0;
      ir_valid_reg <= 1'b0;
      ir_pc_reg <= '0;
      sp_reg <= SP_RESET;
      dm_addr_reg <= '0;
      dm_wdata_reg <= '0;
      dm_we_reg <= 1'b0;
      dm_re_reg <= 1'b0;
      ret_hi_reg <= '0;
      ret_pc_reg <= '0;
      ld_addr_reg <= '0;
      ld_dst_reg <= '0;
      irq_ack_reg <= '0;
      pm_we_reg <= 1'b0;
      pm_waddr_reg <= '0;
      pm_wdata_reg <= '0;
    end else begin
      dm_we_reg <= 1'b0;
      dm_re_reg <= 1'b0;
      irq_ack_reg <= '0;
      pm_we_reg <= 1'b0;
      if (fetch_en) begin
        ir_reg <= PM_DATA;
        ir_valid_reg <= 1'b1;
        ir_pc_reg <= pc_reg;
        pc_reg <= ret_addr;
      end
      unique case (state_reg)
        st_exec: begin
          if (take_irq) begin
            // the unexecuted instruction is resumed after the handler
            dm_addr_reg <= sp_reg;
            dm_wdata_reg <= ir_pc_reg[7:0];
            dm_we_reg <= 1'b1;
            ret_hi_reg <= ir_pc_reg[15:8];
            pc_reg <= vec;
            ir_valid_reg <= 1'b0;
            irq_ack_reg <= irq_pick;
            state_reg <= st_push;
          end else if (ir_valid_reg) begin
            if (two_word) begin
              ir_valid_reg <= 1'b0;
            end
            if (is_load) begin
              ld_addr_reg <= mem_addr;
              ld_dst_reg <= ir_reg.rd;
              dm_addr_reg <= mem_addr;
              dm_re_reg <= is_ext(mem_addr);
              ir_valid_reg <= 1'b0;
              state_reg <= st_load;
              if (!two_word) begin
                pc_reg <= pc_reg;
              end
            end
            if (is_store) begin
              dm_addr_reg <= mem_addr;
              dm_wdata_reg <= rd_val;
              dm_we_reg <= is_ext(mem_addr);
            end
            unique case (ir_reg.op)
              ccf_pkg::call_op: begin
                dm_addr_reg <= sp_reg;
                dm_wdata_reg <= ret_addr[7:0];
                dm_we_reg <= 1'b1;
                ret_hi_reg <= ret_addr[15:8];
                pc_reg <= PM_DATA;
                state_reg <= st_push;
              end
              ccf_pkg::table_read_op: begin
                ret_pc_reg <= pc_reg;
                pc_reg <= {1'b0, z_val[15:1]};
                ld_addr_reg <= z_val;
                ld_dst_reg <= ir_reg.rd;
                ir_valid_reg <= 1'b0;
                state_reg <= st_table;
              end
              ccf_pkg::irq_return_op: begin
                dm_addr_reg <= sp_reg + ccf_pkg::STEP1;
                dm_re_reg <= 1'b1;
                ir_valid_reg <= 1'b0;
                state_reg <= st_pop_hi;
              end
              ccf_pkg::flash_self_write_op: begin
                if (ir_pc_reg >= BOOT_START) begin
                  pm_we_reg <= 1'b1;
                end
                pm_waddr_reg <= z_val;
                pm_wdata_reg <= {rf[ccf_pkg::SPW_HI], rf[ccf_pkg::SPW_LO]};
              end
              default: ;
            endcase
          end
        end
        st_load: state_reg <= st_exec;
        st_push: begin
          dm_addr_reg <= sp_reg - ccf_pkg::STEP1;
          dm_wdata_reg <= ret_hi_reg;
          dm_we_reg <= 1'b1;
          sp_reg <= sp_reg - ccf_pkg::STEP2;
          state_reg <= st_exec;
        end
        st_pop_hi: begin
          ret_hi_reg <= DM_RDATA;
          dm_addr_reg <= sp_reg + ccf_pkg::STEP2;
          dm_re_reg <= 1'b1;
          state_reg <= st_pop_lo;
        end
        st_pop_lo: begin
          pc_reg <= {ret_hi_reg, DM_RDATA};
          sp_reg <= sp_reg + ccf_pkg::STEP2;
          state_reg <= st_exec;
        end
        st_table: begin
          pc_reg <= ret_pc_reg;
          state_reg <= st_exec;
        end
      endcase
    end
  end

  // ==========================================================
  // outputs
  assign PM_ADDR = pc_reg;
  assign PM_WE = pm_we_reg;
  assign PM_WADDR = pm_waddr_reg;
  assign PM_WDATA = pm_wdata_reg;
  assign DM_ADDR = dm_addr_reg;
  assign DM_WDATA = dm_wdata_reg;
  assign DM_WE = dm_we_reg;
  assign DM_RE = dm_re_reg;
  assign IRQ_ACK = irq_ack_reg;
  assign FLAGS = cpu_flag_register_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_pop;
    state_reg == st_pop_hi ##1 state_reg == st_pop_lo;
  endsequence

  a_sign_rel: assert property (exec && !take_irq && ir_reg.op inside {ccf_pkg::add_op,
    ccf_pkg::sub_op, ccf_pkg::xor_op} |=> cpu_flag_register_reg.sign == (cpu_flag_register_reg.neg ^ cpu_flag_register_reg.ovf))
    else $error("sign flag differs from neg xor ovf");
  a_zero_res: assert property (exec && !take_irq && ir_reg.op == ccf_pkg::add_op
    |=> cpu_flag_register_reg.zero == ($past(alu.res) == 8'h00))
    else $error("zero flag wrong after add");
  a_gate_block: assert property (!cpu_flag_register_reg.gate |=> IRQ_ACK == '0)
    else $error("interrupt taken with gate clear");
  a_ack_clears: assert property (|IRQ_ACK |-> !cpu_flag_register_reg.gate)
    else $error("gate not cleared on accept");
  a_ret_gate: assert property (exec && !take_irq && ir_reg.op == ccf_pkg::irq_return_op
    |=> s_pop ##1 cpu_flag_register_reg.gate)
    else $error("return did not set gate");
  a_push_pair: assert property (take_irq |=> DM_WE ##1 DM_WE
    && DM_ADDR == $past(DM_ADDR) - ccf_pkg::STEP1)
    else $error("return address not pushed as two bytes");
  a_irq_prio: assert property (|IRQ_ACK |-> $onehot(IRQ_ACK)
    && (($past(IRQ_REQ) & (IRQ_ACK - 1'b1)) == '0))
    else $error("lower vector not served first");
  a_io_window: assert property (exec && !take_irq && ir_reg.op == ccf_pkg::io_write_op
    && mem_addr != ccf_pkg::FLAG_DATA_ADDR |=> DM_WE && DM_ADDR >= ccf_pkg::IO_BASE
    && DM_ADDR <= ccf_pkg::IO_LAST)
    else $error("io write outside io window");
  a_boot_only: assert property (PM_WE |-> $past(ir_pc_reg) >= BOOT_START)
    else $error("flash write from outside boot section");
endmodule

// ==== bench/ccf_mem_model.sv ====
// Purpose: program flash and data space standing behind the core
// Assumes: reads answer in the same cycle, writes land on the rising edge
// Notes: an unread data bus shows inverted contents, so stale bytes never pass
`timescale 1ns/10ps
module ccf_mem_model (
  // clock
  input wire logic clk,
  // program side
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_data,
  input wire logic pm_we,
  input wire logic [15:0] pm_waddr,
  input wire logic [15:0] pm_wdata,
  // data side
  input wire logic [15:0] dm_addr,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_we,
  input wire logic dm_re,
  output logic [7:0] dm_rdata
);
  logic [15:0] pm [0:255];
  logic [7:0] dm [0:4095];
  // ==========================================
  // reads
  // one whole 16-bit word per program address
  assign pm_data = pm[pm_addr[7:0]];
  // inverse when not read, since a held value could hide a late sample
  assign dm_rdata = dm_re ? dm[dm_addr[11:0]] : ~dm[dm_addr[11:0]];
  // ==========================================
  // writes
  always @(posedge clk) begin
    if (dm_we) begin
      dm[dm_addr[11:0]] <= dm_wdata;
    end
    if (pm_we) begin
      pm[pm_waddr[7:0]] <= pm_wdata;
    end
  end
endmodule

// ==== bench/cpu_core_status_flags_bench.sv ====
// Purpose: self-checking bench for the core datapath and flag register
// Assumes: small programs are written straight into the flash model
// Notes: vectors moved to 0x40 and boot start to 0x80 so both fit the small flash model
`timescale 1ns/10ps
module cpu_core_status_flags_bench;
  logic clk, rst_n, pm_we, dm_we, dm_re;
  logic [15:0] pm_addr, pm_data, pm_waddr, pm_wdata, dm_addr;
  logic [7:0] dm_wdata, dm_rdata, irq, ack, flags;
  int err_count, samples_checked, pw;
  ccf_pkg::ccf_op_t ops [6];
  // ==========================================
  // design and far side
  ccf_core #(.VEC_BASE(16'h0040), .BOOT_START(16'h0080)) i_ccf_core (.CLK(clk), .RST_N(rst_n),
    .PM_ADDR(pm_addr), .PM_DATA(pm_data), .PM_WE(pm_we), .PM_WADDR(pm_waddr),
    .PM_WDATA(pm_wdata), .DM_ADDR(dm_addr), .DM_WDATA(dm_wdata), .DM_WE(dm_we),
    .DM_RE(dm_re), .DM_RDATA(dm_rdata), .IRQ_REQ(irq), .IRQ_ACK(ack), .FLAGS(flags));
  ccf_mem_model i_ccf_mem_model (.clk(clk), .pm_addr(pm_addr), .pm_data(pm_data),
    .pm_we(pm_we), .pm_waddr(pm_waddr), .pm_wdata(pm_wdata), .dm_addr(dm_addr),
    .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re), .dm_rdata(dm_rdata));
  // ==========================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // program words go in order from address zero; the rest stays nop
  task automatic emit(input logic [15:0] w);
    i_ccf_mem_model.pm[pw] = w;
    pw++;
  endtask
  task automatic clear_pm();
    for (int i = 0; i < 256; i++) begin
      i_ccf_mem_model.pm[i] = 16'h0000;
    end
    pw = 0;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check("flags_reset", {8'h00, flags}, 16'h0000);
    rst_n = 1'b1;
  endtask
  function automatic logic [15:0] wd(ccf_pkg::ccf_op_t op, logic [4:0] rd, logic [5:0] fl);
    return {5'(op), rd, fl};
  endfunction
  // expected result and flags; index k follows the ops table
  function automatic logic [15:0] alu_exp(int k, logic [7:0] a, logic [7:0] b,
                                          logic [7:0] f);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] n;
    n = f;
    h = 5'h00;
    case (k)
      0: begin
        r = a + b;
        h = a[3:0] + b[3:0];
      end
      1: begin
        r = a + b + f[0];
        h = a[3:0] + b[3:0] + f[0];
      end
      2: begin
        r = {1'b0, a} - b;
        h = {1'b0, a[3:0]} - b[3:0];
      end
      3: r = {1'b0, a & b};
      4: r = {1'b0, a | b};
      default: r = {1'b0, a ^ b};
    endcase
    // logic ops leave carry and half carry alone and clear overflow
    n[3] = 1'b0;
    if (k < 3) begin
      n[0] = r[8];
      n[5] = h[4];
      n[3] = (k == 2) ? (a[7] ^ b[7]) & (a[7] ^ r[7]) : ~(a[7] ^ b[7]) & (a[7] ^ r[7]);
    end
    n[2] = r[7];
    n[1] = (r[7:0] == 8'h00);
    n[4] = n[2] ^ n[3];
    return {r[7:0], n};
  endfunction
  // ==========================================
  // watchdog: the whole run needs well under 10k cycles
  initial begin
    #400000;
    err_count++;
    test_done();
  end
  // ==========================================
  // tests
  initial begin
    logic [7:0] a, b, f0, lo;
    logic [15:0] e;
    logic [2:0] kb, jb;
    logic g;
    int n;
    rst_n = 1'b0;
    irq = 8'h00;
    err_count = 0;
    samples_checked = 0;
    ops = '{ccf_pkg::add_op, ccf_pkg::adc_op, ccf_pkg::sub_op, ccf_pkg::and_op,
            ccf_pkg::or_op, ccf_pkg::xor_op};
    void'($urandom(32'h33a0));
    // alu ops on random and boundary operands, flags preset through io 0x3F
    for (int k = 0; k < 6; k++) begin
      for (int t = 0; t < 6; t++) begin
        a = 8'($urandom);
        b = 8'($urandom);
        f0 = 8'($urandom);
        if (t == 0) begin
          a = 8'h7F;
          b = 8'h01;
        end
        if (t == 1) begin
          a = 8'h80;
          b = (k == 2) ? 8'h01 : 8'h80;
        end
        clear_pm();
        emit(wd(ccf_pkg::imm_load_op, 5'd3, 6'h00));
        emit({8'h00, f0});
        emit(wd(ccf_pkg::io_write_op, 5'd3, 6'h3F));
        emit(wd(ccf_pkg::imm_load_op, 5'd1, 6'h00));
        emit({8'h00, a});
        emit(wd(ccf_pkg::imm_load_op, 5'd2, 6'h00));
        emit({8'h00, b});
        emit(wd(ops[k], 5'd1, 6'd2));
        emit(wd(ccf_pkg::io_write_op, 5'd1, 6'h10));
        do_reset();
        for (n = 0; n < 40 && dm_we !== 1'b1; n++) step();
        e = alu_exp(k, a, b, f0);
        check("store_addr", dm_addr, 16'h0030);
        check("alu_result", {8'h00, dm_wdata}, {8'h00, e[15:8]});
        check("alu_flags", {8'h00, flags}, {8'h00, e[7:0]});
      end
    end
    // bit copy through bit 6, stored to the extended io window
    for (int t = 0; t < 6; t++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      kb = 3'($urandom);
      jb = 3'($urandom);
      clear_pm();
      emit(wd(ccf_pkg::imm_load_op, 5'd1, 6'h00));
      emit({8'h00, a});
      emit(wd(ccf_pkg::reg_bit_to_flag_op, 5'd1, {3'b000, kb}));
      emit(wd(ccf_pkg::imm_load_op, 5'd2, 6'h00));
      emit({8'h00, b});
      emit(wd(ccf_pkg::flag_to_reg_bit_op, 5'd2, {3'b000, jb}));
      emit(wd(ccf_pkg::direct_write_op, 5'd2, 6'h00));
      emit(16'h0060);
      do_reset();
      for (n = 0; n < 40 && dm_we !== 1'b1; n++) step();
      b[jb] = a[kb];
      check("ext_addr", dm_addr, 16'h0060);
      check("copy_data", {8'h00, dm_wdata}, {8'h00, b});
      check("copy_flag", {15'h0000, flags[6]}, {15'h0000, a[kb]});
    end
    // interrupt entry, priority, push, return and gate control
    clear_pm();
    emit(wd(ccf_pkg::imm_load_op, 5'd3, 6'h00));
    emit(16'h003C);
    emit(wd(ccf_pkg::io_write_op, 5'd3, 6'h3F));
    pw = 6;
    emit(wd(ccf_pkg::irq_gate_set_op, 5'd0, 6'h00));
    for (int i = 0; i < 3; i++) emit(wd(ccf_pkg::irq_gate_clear_op, 5'd0, 6'h00));
    for (int i = 0; i < 8; i++) i_ccf_mem_model.pm[64 + 2 * i] = wd(ccf_pkg::irq_return_op, 5'd0, 6'h00);
    irq = 8'($urandom) | 8'h80;
    lo = irq & (~irq + 8'h01);
    do_reset();
    g = 1'b0;
    for (n = 0; n < 40 && ack === 8'h00; n++) begin
      g = flags[7];
      step();
    end
    check("gate_before_ack", {15'h0000, g}, 16'h0001);
    check("ack_lowest", {8'h00, ack}, {8'h00, lo});
    check("gate_on_entry", {15'h0000, flags[7]}, 16'h0000);
    check("push_lo_addr", dm_we ? dm_addr : 16'hFFFF, 16'h04FF);
    check("push_lo_data", {8'h00, dm_wdata}, 16'h0007);
    // the vector address stands on the fetch bus only in the acknowledge cycle
    e = 16'h0040;
    for (int i = 0; i < 8; i++) if (lo[i]) e = 16'h0040 + 16'(2 * i);
    check("vector_addr", pm_addr, e);
    irq = 8'h00;
    step();
    check("push_hi_addr", dm_we ? dm_addr : 16'hFFFF, 16'h04FE);
    check("push_hi_data", {8'h00, dm_wdata}, 16'h0000);
    for (n = 0; n < 12 && flags[7] !== 1'b1; n++) step();
    check("gate_on_return", {15'h0000, flags[7]}, 16'h0001);
    check("flags_kept", {8'h00, flags[6:0]}, 16'h003C);
    for (n = 0; n < 8 && flags[7] !== 1'b0; n++) step();
    check("gate_cleared", {15'h0000, flags[7]}, 16'h0000);
    irq = 8'($urandom) | 8'h01;
    g = 1'b0;
    repeat (12) begin
      step();
      g = g | (ack !== 8'h00);
    end
    check("no_ack_gated", {15'h0000, g}, 16'h0000);
    // call into the boot area, self-write below and inside it, table read, io load
    irq = 8'h00;
    a = 8'($urandom);
    b = 8'($urandom);
    lo = 8'($urandom);
    e = 16'($urandom);
    clear_pm();
    emit(wd(ccf_pkg::imm_load_op, 5'd0, 6'h00));
    emit({8'h00, a});
    emit(wd(ccf_pkg::imm_load_op, 5'd1, 6'h00));
    emit({8'h00, b});
    emit(wd(ccf_pkg::imm_load_op, 5'd30, 6'h00));
    emit(16'h0061);
    emit(wd(ccf_pkg::imm_load_op, 5'd31, 6'h00));
    emit(16'h0000);
    emit(wd(ccf_pkg::flash_self_write_op, 5'd0, 6'h00));
    emit(wd(ccf_pkg::call_op, 5'd0, 6'h00));
    emit(16'h0080);
    emit(wd(ccf_pkg::table_read_op, 5'd5, 6'h00));
    emit(wd(ccf_pkg::io_read_op, 5'd6, 6'h05));
    emit(wd(ccf_pkg::io_write_op, 5'd5, 6'h10));
    emit(wd(ccf_pkg::io_write_op, 5'd6, 6'h11));
    i_ccf_mem_model.pm[8'h80] = wd(ccf_pkg::flash_self_write_op, 5'd0, 6'h00);
    i_ccf_mem_model.pm[8'h81] = wd(ccf_pkg::irq_return_op, 5'd0, 6'h00);
    i_ccf_mem_model.pm[8'h30] = e;
    // targets preset to the inverse so a missing store cannot pass
    i_ccf_mem_model.dm[12'h025] = lo;
    i_ccf_mem_model.dm[12'h030] = ~e[15:8];
    i_ccf_mem_model.dm[12'h031] = ~lo;
    do_reset();
    n = 0;
    repeat (32) begin
      step();
      if (pm_we === 1'b1) n++;
    end
    check("self_write_count", 16'(n), 16'h0001);
    check("self_write_word", i_ccf_mem_model.pm[8'h61], {b, a});
    check("call_ret_lo", {8'h00, i_ccf_mem_model.dm[12'h4FF]}, 16'h000B);
    check("table_byte", {8'h00, i_ccf_mem_model.dm[12'h030]}, {8'h00, e[15:8]});
    check("io_load", {8'h00, i_ccf_mem_model.dm[12'h031]}, {8'h00, lo});
    test_done();
  end
endmodule
